// ---- inc/wd_pkg.sv ----
// Purpose: Shared constants of the watchdog and reset-cause block
// Assumes: 8-bit register data, byte addresses on the core data bus
// Notes:   Counts of the time-out are in oscillator cycles
package wd_pkg;

  // Register addresses
  localparam logic [7:0] RC_DATA_ADDR    = 8'h54;
  localparam logic [7:0] IO_SPACE_OFFSET = 8'h20;
  localparam logic [7:0] RC_IO_ADDR      = 8'(RC_DATA_ADDR - IO_SPACE_OFFSET);
  localparam logic [7:0] CS_DATA_ADDR    = 8'h60;
  localparam logic [7:0] UNMAPPED_RDATA  = 8'h00;

  // Reset-cause field positions
  localparam int unsigned RC_SCAN_BIT = 4;
  localparam int unsigned RC_WD_BIT   = 3;
  localparam int unsigned RC_BO_BIT   = 2;
  localparam int unsigned RC_EXT_BIT  = 1;
  localparam int unsigned RC_PON_BIT  = 0;

  // Control and status field positions
  localparam int unsigned CS_FLAG_BIT  = 7;
  localparam int unsigned CS_IE_BIT    = 6;
  localparam int unsigned CS_PS_HI_BIT = 5;
  localparam int unsigned CS_CE_BIT    = 4;
  localparam int unsigned CS_RE_BIT    = 3;
  localparam int unsigned CS_PS_LO_MSB = 2;

  // Reset values
  localparam logic [7:0] RC_RESET_VAL = 8'h00;
  localparam logic [7:0] CS_RESET_VAL = 8'h00;

  // Timing
  localparam logic [2:0] CHANGE_WINDOW_CYCLES = 3'h4;
  localparam logic [3:0] PRESCALE_MAX_CODE    = 4'h9;
  localparam int unsigned TIMEOUT_BASE_CYCLES = 2048;
  localparam int unsigned TIMEOUT_CNT_W       = 21;

endpackage : wd_pkg

// ---- inc/wd_link_if.sv ----
// Purpose: Carrier between watchdog control, sampler and counter
// Assumes: All members on the core clock
// Notes:   Tick and expire are one-cycle pulses
interface wd_link_if;
  logic       tick;
  logic       restart;
  logic       run;
  logic [3:0] prescale;
  logic       expire;

  modport sampler (output tick);
  modport counter (input tick, restart, run, prescale, output expire);
  modport ctrl    (input expire, output restart, run, prescale);
endinterface : wd_link_if

// ---- logic/osc_tick_sampler.sv ----
// Purpose: Bring the slow oscillator into the core clock as a tick
// Assumes: Oscillator far slower than the core clock
// Notes:   One tick per rising oscillator edge
module osc_tick_sampler
  import wd_pkg::*;
(
  input  wire logic  core_clk_i,
  input  wire logic  rst_i,
  input  wire logic  osc_clk_i,
  wd_link_if.sampler link
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic tick;
  } samp_t;

  samp_t s;
  samp_t next_s;

  // Two-stage synchroniser, then rising-edge detect on stage two
  always_comb
  begin
    next_s      = s;
    next_s.s1   = osc_clk_i;
    next_s.s2   = s.s1;
    next_s.s3   = s.s2;
    next_s.tick = s.s2 & ~s.s3;
  end

  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
      s <= '0;
    else
      s <= next_s;
  end

  assign link.tick = s.tick;

endmodule // osc_tick_sampler

// ---- logic/timeout_counter.sv ----
// Purpose: Count oscillator ticks up to the selected time-out
// Assumes: Tick is a one-cycle pulse on the core clock
// Notes:   Reserved select codes fall back to the longest period
module timeout_counter
  import wd_pkg::*;
#(
  parameter int unsigned BASE_CYCLES = TIMEOUT_BASE_CYCLES,
  parameter int unsigned CNT_W       = TIMEOUT_CNT_W
)
(
  input  wire logic  core_clk_i,
  input  wire logic  rst_i,
  wd_link_if.counter link
);

  typedef struct packed {
    logic [CNT_W-1:0] count;
    logic             expire;
  } cnt_t;

  cnt_t             s;
  cnt_t             next_s;
  logic [3:0]       code;
  logic [CNT_W-1:0] last;

  // Clamp reserved codes, derive the last count value
  always_comb
  begin
    code = (link.prescale > PRESCALE_MAX_CODE) ? PRESCALE_MAX_CODE
                                               : link.prescale;
    last = CNT_W'((CNT_W'(BASE_CYCLES) << code) - 1'b1);
  end

  // Count ticks; restart or stop clears the count
  always_comb
  begin
    next_s        = s;
    next_s.expire = 1'b0;
    if (link.restart || !link.run)
      next_s.count = '0;
    else if (link.tick)
    begin
      if (s.count >= last)
      begin
        next_s.count  = '0;
        next_s.expire = 1'b1;
      end
      else
        next_s.count = CNT_W'(s.count + 1'b1);
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
      s <= '0;
    else
      s <= next_s;
  end

  assign link.expire = s.expire;

endmodule // timeout_counter

// ---- logic/watchdog_with_reset_flags.sv ----
// Purpose: Watchdog with control/status and reset-cause registers
// Assumes: rst_i is the power-on reset; other resets come as pulses
// Notes:   Registers reached by core load/store; cause flags also by short I/O access
//          The block is not cleared by its own system reset pulse;
//          only rst_i returns it to the power-on state, so the cause
//          flags survive every reset they record
//
// Functional notes
// - Test-port reset sets flag; clear by write zero
// - Watchdog reset sets flag; clear by write zero
// - Brown-out reset sets flag; clear by write zero
// - External reset sets flag; clear by write zero
// - Power-on flag set by power-on, write-zero clear
// - Cause flags at 0x54, short I/O 0x34
// - Time-out sets interrupt flag; vector or one clears
// - Request needs global and watchdog interrupt enables
// - Vector in combined mode clears enable and flag
// - Unserviced combined-mode interrupt then next time-out resets
// - Enable bits select stopped, interrupt, reset, combined
// - Programmed fuse forces reset mode
// - Clearing reset enable, prescaler change need window
// - Change window closes after four cycles
// - Reset enable held set while watchdog flag set
// - Select gives 2048 doubling to 1048576 cycles
// - Select split: bit 5 high, bits 2:0 low
// - Control register at 0x60, load/store only
// - Counter counts separate slow oscillator cycles
// - Open window with enable bits, then write values
// - Restart instruction clears the counter
// - Reset time-out gives one-cycle reset pulse
module watchdog_with_reset_flags
  import wd_pkg::*;
#(
  parameter int unsigned TIMEOUT_BASE = TIMEOUT_BASE_CYCLES
)
(
  input  wire logic       core_clk_i,
  input  wire logic       rst_i,
  // Core register access
  input  wire logic [7:0] bus_addr_i,
  input  wire logic       bus_io_space_i,
  input  wire logic       bus_we_i,
  input  wire logic       bus_re_i,
  input  wire logic [7:0] bus_wdata_i,
  output logic      [7:0] bus_rdata_o,
  // Core events
  input  wire logic       restart_i,
  input  wire logic       global_int_enable_i,
  input  wire logic       irq_ack_i,
  output logic            irq_o,
  // Reset sources from the reset controller
  input  wire logic       scan_reset_i,
  input  wire logic       brownout_reset_i,
  input  wire logic       ext_reset_i,
  output logic            sys_reset_o,
  // Slow oscillator and fuse
  input  wire logic       osc_clk_i,
  input  wire logic       always_on_fuse_i
);

  typedef struct packed {
    logic       fuse_s1;
    logic       fuse_s2;
    logic       test_port_reset_flag;
    logic       watchdog_reset_cause_flag;
    logic       brownout_cause_flag;
    logic       external_pin_reset_flag;
    logic       power_on_cause_flag;
    logic       watchdog_interrupt_flag;
    logic       watchdog_interrupt_enable;
    logic       reset_enable;
    logic [3:0] timeout_prescale_select;
    logic       change_enable;
    logic [2:0] window_count;
    logic [7:0] rdata;
    logic       irq;
    logic       sys_reset;
  } state_t;

  // Working modes, one-hot
  typedef enum logic [3:0] {
    MODE_STOPPED   = 4'b0001,
    MODE_INTERRUPT = 4'b0010,
    MODE_RESET     = 4'b0100,
    MODE_COMBINED  = 4'b1000
  } wd_mode_t;

  // Power-on state; fuse sampler starts at unprogrammed
  localparam state_t STATE_RESET = '{
    fuse_s1:                   1'b1,
    fuse_s2:                   1'b1,
    test_port_reset_flag:      RC_RESET_VAL[RC_SCAN_BIT],
    watchdog_reset_cause_flag: RC_RESET_VAL[RC_WD_BIT],
    brownout_cause_flag:       RC_RESET_VAL[RC_BO_BIT],
    external_pin_reset_flag:   RC_RESET_VAL[RC_EXT_BIT],
    power_on_cause_flag:       1'b1,
    watchdog_interrupt_flag:   CS_RESET_VAL[CS_FLAG_BIT],
    watchdog_interrupt_enable: CS_RESET_VAL[CS_IE_BIT],
    reset_enable:              CS_RESET_VAL[CS_RE_BIT],
    timeout_prescale_select:   {CS_RESET_VAL[CS_PS_HI_BIT],
                                CS_RESET_VAL[CS_PS_LO_MSB:0]},
    change_enable:             CS_RESET_VAL[CS_CE_BIT],
    window_count:              3'h0,
    rdata:                     UNMAPPED_RDATA,
    irq:                       1'b0,
    sys_reset:                 1'b0
  };

  state_t s;
  state_t next_s;

  wd_link_if link ();

  // Decoded accesses and derived modes
  logic       fuse_programmed;
  logic       reset_en_eff;
  logic       int_en_eff;
  logic       sel_rc;
  logic       sel_cs;
  logic       wr_rc;
  logic       wr_cs;
  logic       open_window;
  logic       reset_now;
  logic       flag_set;
  logic       ack_hit;
  logic       combined;
  logic [7:0] rc_view;
  logic [7:0] cs_view;
  logic [3:0] wr_prescale;
  wd_mode_t   mode;

  // Oscillator edges become core-clock ticks before counting
  osc_tick_sampler u_sampler (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .osc_clk_i  (osc_clk_i),
    .link       (link.sampler)
  );

  timeout_counter #(
    .BASE_CYCLES (TIMEOUT_BASE),
    .CNT_W       (TIMEOUT_CNT_W)
  ) u_counter (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .link       (link.counter)
  );

  // Effective mode from fuse and enable bits
  // A set watchdog cause flag pins reset enable high, so a failing
  // program keeps being reset until it clears that flag first
  always_comb
  begin
    fuse_programmed = ~s.fuse_s2;
    reset_en_eff    = fuse_programmed | s.reset_enable
                      | s.watchdog_reset_cause_flag;
    int_en_eff      = ~fuse_programmed
                      & s.watchdog_interrupt_enable;
  end

  // Working mode; a programmed fuse already shows as reset-only
  always_comb
  begin
    unique case ({reset_en_eff, int_en_eff})
      2'b00: mode = MODE_STOPPED;
      2'b01: mode = MODE_INTERRUPT;
      2'b10: mode = MODE_RESET;
      2'b11: mode = MODE_COMBINED;
    endcase
    combined = (mode == MODE_COMBINED);
  end

  // Counter steering
  assign link.run      = (mode != MODE_STOPPED);
  assign link.restart  = restart_i;
  assign link.prescale = s.timeout_prescale_select;

  // Register decode
  // Control register has no short I/O alias
  always_comb
  begin
    sel_rc = bus_io_space_i ? (bus_addr_i == RC_IO_ADDR)
                            : (bus_addr_i == RC_DATA_ADDR);
    sel_cs = ~bus_io_space_i & (bus_addr_i == CS_DATA_ADDR);
    wr_rc  = bus_we_i & sel_rc;
    wr_cs  = bus_we_i & sel_cs;
  end

  // Read views of both registers
  always_comb
  begin
    rc_view              = '0;
    rc_view[RC_SCAN_BIT] = s.test_port_reset_flag;
    rc_view[RC_WD_BIT]   = s.watchdog_reset_cause_flag;
    rc_view[RC_BO_BIT]   = s.brownout_cause_flag;
    rc_view[RC_EXT_BIT]  = s.external_pin_reset_flag;
    rc_view[RC_PON_BIT]  = s.power_on_cause_flag;
    cs_view                 = '0;
    cs_view[CS_FLAG_BIT]    = s.watchdog_interrupt_flag;
    cs_view[CS_IE_BIT]      = int_en_eff;
    cs_view[CS_PS_HI_BIT]   = s.timeout_prescale_select[3];
    cs_view[CS_CE_BIT]      = s.change_enable;
    cs_view[CS_RE_BIT]      = reset_en_eff;
    cs_view[CS_PS_LO_MSB:0] = s.timeout_prescale_select[2:0];
  end

  // Time-out actions
  // In combined mode the first expire only raises the flag; a second
  // expire with the flag still pending means the handler never ran
  always_comb
  begin
    flag_set  = link.expire & int_en_eff;
    reset_now = link.expire & reset_en_eff
                & (~int_en_eff | s.watchdog_interrupt_flag);
    ack_hit   = irq_ack_i & s.watchdog_interrupt_flag;
    open_window = s.change_enable;
    wr_prescale = {bus_wdata_i[CS_PS_HI_BIT],
                   bus_wdata_i[CS_PS_LO_MSB:0]};
  end

  // Next state
  always_comb
  begin
    next_s = s;

    // Fuse level through two flops
    // Sampler starts at unprogrammed: a programmed fuse takes effect
    // two cycles after reset, never the other way round
    next_s.fuse_s1 = always_on_fuse_i;
    next_s.fuse_s2 = s.fuse_s1;

    // Reset-cause flags: write zero clears, event wins
    if (wr_rc)
    begin
      next_s.test_port_reset_flag      = s.test_port_reset_flag
                                         & bus_wdata_i[RC_SCAN_BIT];
      next_s.watchdog_reset_cause_flag = s.watchdog_reset_cause_flag
                                         & bus_wdata_i[RC_WD_BIT];
      next_s.brownout_cause_flag       = s.brownout_cause_flag
                                         & bus_wdata_i[RC_BO_BIT];
      next_s.external_pin_reset_flag   = s.external_pin_reset_flag
                                         & bus_wdata_i[RC_EXT_BIT];
      next_s.power_on_cause_flag       = s.power_on_cause_flag
                                         & bus_wdata_i[RC_PON_BIT];
    end
    if (scan_reset_i)
      next_s.test_port_reset_flag = 1'b1;
    if (reset_now)
      next_s.watchdog_reset_cause_flag = 1'b1;
    if (brownout_reset_i)
      next_s.brownout_cause_flag = 1'b1;
    if (ext_reset_i)
      next_s.external_pin_reset_flag = 1'b1;

    // Vector execution clears the flag, and in combined mode the enable
    if (ack_hit)
    begin
      next_s.watchdog_interrupt_flag = 1'b0;
      if (combined)
        next_s.watchdog_interrupt_enable = 1'b0;
    end

    // Change window closes on its own after the last cycle
    // Window counts core cycles, not oscillator ticks, so the unlock
    // must be followed by the value write within a few instructions
    if (s.change_enable)
    begin
      if (s.window_count == 3'(CHANGE_WINDOW_CYCLES - 1'b1))
      begin
        next_s.change_enable = 1'b0;
        next_s.window_count  = 3'h0;
      end
      else
        next_s.window_count = 3'(s.window_count + 1'b1);
    end

    // Control/status write
    // Setting reset enable is always allowed; only loosening the
    // watchdog (clearing it, new period) needs the open window
    if (wr_cs)
    begin
      if (bus_wdata_i[CS_FLAG_BIT])
        next_s.watchdog_interrupt_flag = 1'b0;
      next_s.watchdog_interrupt_enable = bus_wdata_i[CS_IE_BIT];
      if (bus_wdata_i[CS_RE_BIT])
        next_s.reset_enable = 1'b1;
      else if (open_window)
        next_s.reset_enable = 1'b0;
      if (open_window)
        next_s.timeout_prescale_select = wr_prescale;
      if (bus_wdata_i[CS_CE_BIT] && bus_wdata_i[CS_RE_BIT])
      begin
        next_s.change_enable = 1'b1;
        next_s.window_count  = 3'h0;
      end
      else if (!bus_wdata_i[CS_CE_BIT])
      begin
        next_s.change_enable = 1'b0;
        next_s.window_count  = 3'h0;
      end
    end

    // Hardware set of the interrupt flag wins over any clear
    if (flag_set)
      next_s.watchdog_interrupt_flag = 1'b1;

    // One-cycle system reset pulse
    next_s.sys_reset = reset_now;

    // Interrupt request gated by both enables
    next_s.irq = next_s.watchdog_interrupt_flag
                 & next_s.watchdog_interrupt_enable
                 & s.fuse_s2
                 & global_int_enable_i;

    // Registered read data, zero for unmapped addresses
    // A read therefore answers one cycle after its strobe
    if (bus_re_i && sel_rc)
      next_s.rdata = rc_view;
    else if (bus_re_i && sel_cs)
      next_s.rdata = cs_view;
    else
      next_s.rdata = UNMAPPED_RDATA;
  end

  // State register; power-on reset only
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
      s <= STATE_RESET;
    else
      s <= next_s;
  end

  // Outputs straight from flops
  // System reset pulse leaves this block running; the flag records it
  assign bus_rdata_o = s.rdata;
  assign irq_o       = s.irq;
  assign sys_reset_o = s.sys_reset;

endmodule // watchdog_with_reset_flags

// ---- dv/wd_chk.sv ----
// Purpose: Port-level assertions for the watchdog block
// Assumes: One core clock, rst_i async active high
// Notes:   Bound into the top module at the foot of this file
module wd_chk
  import wd_pkg::*;
(
  input wire logic       core_clk_i,
  input wire logic       rst_i,
  input wire logic [7:0] bus_addr_i,
  input wire logic       bus_io_space_i,
  input wire logic       bus_we_i,
  input wire logic       bus_re_i,
  input wire logic [7:0] bus_wdata_i,
  input wire logic [7:0] bus_rdata_o,
  input wire logic       restart_i,
  input wire logic       global_int_enable_i,
  input wire logic       irq_ack_i,
  input wire logic       irq_o,
  input wire logic       scan_reset_i,
  input wire logic       brownout_reset_i,
  input wire logic       ext_reset_i,
  input wire logic       sys_reset_o,
  input wire logic       osc_clk_i,
  input wire logic       always_on_fuse_i
);
  timeunit 1ns;
  timeprecision 1ps;
  logic rc_rd;
  logic cs_acc;
  logic ce_wr;

  // Decoded accesses
  assign rc_rd  = bus_re_i && (bus_io_space_i ? bus_addr_i == RC_IO_ADDR
                                              : bus_addr_i == RC_DATA_ADDR);
  assign cs_acc = !bus_io_space_i && bus_addr_i == CS_DATA_ADDR;
  assign ce_wr  = bus_we_i && cs_acc && bus_wdata_i[4:3] == 2'b11;

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  AST_IDLE_ZERO: assert property (!bus_re_i |=> bus_rdata_o == 8'h00)
    else $error("read data not zero without read");
  AST_CS_NO_IO: assert property (bus_re_i && bus_io_space_i &&
    bus_addr_i == CS_DATA_ADDR |=> bus_rdata_o == 8'h00)
    else $error("control reached through short space");
  AST_RST_PULSE: assert property (sys_reset_o |=> !sys_reset_o)
    else $error("system reset longer than one cycle");
  AST_IRQ_GATE: assert property (irq_o |-> $past(global_int_enable_i))
    else $error("request without global enable");
  AST_SCAN_FLAG: assert property (scan_reset_i ##[1:8] rc_rd
    |=> bus_rdata_o[4]) else $error("scan cause flag missing");
  AST_BO_FLAG: assert property (brownout_reset_i ##[1:8] rc_rd
    |=> bus_rdata_o[2]) else $error("brown-out flag missing");
  AST_EXT_FLAG: assert property (ext_reset_i ##[1:8] rc_rd
    |=> bus_rdata_o[1]) else $error("external flag missing");
  AST_WD_FLAG: assert property (sys_reset_o ##[1:4] rc_rd
    |=> bus_rdata_o[3]) else $error("watchdog cause flag missing");
  AST_CE_OPEN: assert property (ce_wr ##1 !bus_we_i ##1
    (bus_re_i && cs_acc) |=> bus_rdata_o[4])
    else $error("change enable not open");
  AST_CE_CLOSE: assert property (ce_wr ##1 !bus_we_i [*4] ##1
    (bus_re_i && cs_acc) |=> !bus_rdata_o[4])
    else $error("change enable not closed");
  AST_FUSE_LOCK: assert property (!always_on_fuse_i [*4] ##1
    (bus_re_i && cs_acc && !always_on_fuse_i)
    |=> bus_rdata_o[3] && !bus_rdata_o[6])
    else $error("fuse does not force reset mode");
  AST_ACK_CLEAR: assert property (irq_ack_i && irq_o
    |-> ##[1:2] !irq_o) else $error("vector does not clear request");
endmodule // wd_chk

bind watchdog_with_reset_flags wd_chk wd_chk_i (.core_clk_i, .rst_i,
  .bus_addr_i, .bus_io_space_i, .bus_we_i, .bus_re_i, .bus_wdata_i,
  .bus_rdata_o, .restart_i, .global_int_enable_i, .irq_ack_i, .irq_o,
  .scan_reset_i, .brownout_reset_i, .ext_reset_i, .sys_reset_o,
  .osc_clk_i, .always_on_fuse_i);

// ---- dv/watchdog_with_reset_flags_tb.sv ----
// Purpose: Self-checking bench for the watchdog block
// Assumes: Base time-out shortened to 4 ticks, oscillator 40 ns
// Notes:   Reads queue their expected value, a monitor compares
module watchdog_with_reset_flags_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import wd_pkg::*;
  logic       core_clk_i = 0;
  logic       rst_i      = 1;
  logic [7:0] addr       = 0;
  logic [7:0] wdata      = 0;
  logic       io = 0, we = 0, re = 0, gie = 0, fuse = 1, osc = 0;
  logic [4:0] ev         = 0;
  logic [7:0] rdata;
  logic       irq;
  logic       sysr;
  logic       rd_pend    = 0;
  logic [7:0] exp_q[$];
  int         failures   = 0;
  int         samples_checked = 0;
  int         n;

  // Core clock and unrelated slow oscillator
  always #2 core_clk_i = ~core_clk_i;
  always #20 osc = ~osc;

  watchdog_with_reset_flags #(.TIMEOUT_BASE(4)) watchdog_with_reset_flags_i (
    .core_clk_i, .rst_i, .bus_addr_i(addr), .bus_io_space_i(io),
    .bus_we_i(we), .bus_re_i(re), .bus_wdata_i(wdata), .bus_rdata_o(rdata),
    .restart_i(ev[0]), .global_int_enable_i(gie), .irq_ack_i(ev[1]),
    .irq_o(irq), .scan_reset_i(ev[4]), .brownout_reset_i(ev[3]),
    .ext_reset_i(ev[2]), .sys_reset_o(sysr), .osc_clk_i(osc),
    .always_on_fuse_i(fuse));

  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic conclude;
    $display("counts: checked=%0d failed=%0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // One register access; a read queues d as its expected value
  task automatic acc(input logic w, input logic [7:0] a, input logic i,
                     input logic [7:0] d);
    @(posedge core_clk_i);
    we    <= w;
    re    <= !w;
    addr  <= a;
    io    <= i;
    wdata <= d;
    if (!w)
      exp_q.push_back(d);
    @(posedge core_clk_i);
    we <= 0;
    re <= 0;
  endtask

  task automatic pls(input int b);
    @(posedge core_clk_i);
    ev[b] <= 1;
    @(posedge core_clk_i);
    ev[b] <= 0;
  endtask

  // Timed change sequence: open window, then write d
  task automatic cfg(input logic [7:0] d);
    acc(1, 8'h60, 0, 8'h18);
    acc(1, 8'h60, 0, d);
  endtask

  // Bounded wait for irq (w=0) or system reset (w=1)
  task automatic hold(input int w, input int lim, output int c);
    for (c = 0; c < lim; c++)
    begin
      @(posedge core_clk_i);
      if ((w ? sysr : irq) === 1'b1)
        return;
    end
    failures++;
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, c, lim);
    conclude();
  endtask

  // Read monitor: answer is due one cycle after the read
  always @(posedge core_clk_i)
  begin
    if (rd_pend)
      cmp(rdata, exp_q.pop_front());
    rd_pend <= re;
  end

  initial
  begin
    void'($urandom(49420));
    repeat (6) @(posedge core_clk_i);
    rst_i <= 0;
    acc(0, 8'h54, 0, 8'h01);
    acc(0, 8'h34, 1, 8'h01);
    acc(0, 8'h60, 0, 8'h00);
    acc(0, 8'h60, 1, 8'h00);
    acc(1, 8'h70, 0, 8'($urandom));
    acc(0, 8'h70, 0, 8'h00);
    $display("test reset values done");
    pls(4);
    pls(3);
    pls(2);
    acc(0, 8'h54, 0, 8'h17);
    acc(1, 8'h54, 0, 8'hf5);
    acc(0, 8'h34, 1, 8'h15);
    acc(1, 8'h34, 1, 8'h00);
    acc(0, 8'h54, 0, 8'h00);
    $display("test reset causes done");
    cfg(8'h21);
    acc(0, 8'h60, 0, 8'h21);
    acc(1, 8'h60, 0, 8'h29);
    acc(1, 8'h60, 0, 8'h00);
    acc(0, 8'h60, 0, 8'h29);
    acc(1, 8'h60, 0, 8'h18);
    repeat (3) @(posedge core_clk_i);
    acc(0, 8'h60, 0, 8'h29);
    acc(1, 8'h60, 0, 8'h00);
    acc(0, 8'h60, 0, 8'h29);
    acc(1, 8'h60, 0, 8'h18);
    acc(0, 8'h60, 0, 8'h39);
    acc(1, 8'h60, 0, 8'h00);
    acc(0, 8'h60, 0, 8'h00);
    $display("test change window done");
    for (int c = 0; c < 2; c++)
    begin
      cfg(8'h08 | 8'(c));
      pls(0);
      hold(1, 200, n);
      cmp({7'h0, n inside {[(40<<c)-10:(40<<c)+8]}}, 8'h01);
      acc(0, 8'h54, 0, 8'h08);
      cfg(8'h00);
      acc(0, 8'h60, 0, 8'h08);
      acc(1, 8'h54, 0, 8'h00);
      acc(0, 8'h60, 0, 8'h00);
    end
    cfg(8'h2a);
    pls(0);
    hold(1, 21000, n);
    cmp({7'h0, n inside {[20470:20490]}}, 8'h01);
    acc(1, 8'h54, 0, 8'h00);
    cfg(8'h00);
    $display("test reset mode done");
    gie <= 1;
    acc(1, 8'h60, 0, 8'h40);
    pls(0);
    hold(0, 200, n);
    acc(0, 8'h60, 0, 8'hc0);
    pls(1);
    acc(0, 8'h60, 0, 8'h40);
    cmp({7'h0, irq}, 8'h00);
    gie <= 0;
    repeat (60) @(posedge core_clk_i);
    cmp({7'h0, irq}, 8'h00);
    acc(0, 8'h60, 0, 8'hc0);
    pls(0);
    acc(1, 8'h60, 0, 8'hc0);
    acc(0, 8'h60, 0, 8'h40);
    acc(1, 8'h60, 0, 8'h00);
    $display("test interrupt mode done");
    acc(1, 8'h60, 0, 8'h48);
    gie <= 1;
    pls(0);
    hold(0, 200, n);
    pls(1);
    acc(0, 8'h60, 0, 8'h08);
    hold(1, 60, n);
    acc(1, 8'h54, 0, 8'h00);
    acc(1, 8'h60, 0, 8'h48);
    pls(0);
    hold(0, 200, n);
    hold(1, 60, n);
    acc(1, 8'h54, 0, 8'h00);
    cfg(8'h80);
    acc(0, 8'h60, 0, 8'h00);
    $display("test combined mode done");
    pls(0);
    fuse <= 0;
    repeat (4) @(posedge core_clk_i);
    acc(1, 8'h60, 0, 8'h40);
    acc(0, 8'h60, 0, 8'h08);
    fuse <= 1;
    $display("test fuse done");
    repeat (2) @(posedge core_clk_i);
    conclude();
  end
endmodule // watchdog_with_reset_flags_tb
